// ===== hw/ucs_pkg.sv
// shared constants and types for the endpoint-zero host control block
package ucs_pkg;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_CSR = 12'h102;
    localparam logic [11:0] IDX_NAKLIM = 12'h104;
    localparam logic [11:0] IDX_TOG = 12'h105;
    localparam logic [11:0] IDX_ISTS = 12'h106;
    localparam logic [11:0] IDX_IMASK = 12'h107;
    // control/status bit positions
    localparam int B_NAK_TIMEOUT_FLAG = 7;
    localparam int B_STATUS = 6;
    localparam int B_INREQ = 5;
    localparam int B_ERROR = 4;
    localparam int B_SETUP = 3;
    localparam int B_STALLED = 2;
    localparam int B_TX_PACKET_READY = 1;
    localparam int B_RX_PACKET_READY = 0;
    // reset values
    localparam logic [7:0] CSR_RST = 8'h00;
    localparam logic [7:0] NAKLIM_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    // attempts without any answer before the error flag
    localparam logic [1:0] MAX_TRIES = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        TOK_SETUP,
        TOK_OUT,
        TOK_IN
    } ucs_tok_t;

    typedef enum logic [2:0] {
        RSP_ACK,
        RSP_NAK,
        RSP_STALL,
        RSP_DATA,
        RSP_NONE
    } ucs_rsp_code_t;

    // one transaction launched towards the bus engine
    typedef struct packed {
        logic valid;
        ucs_tok_t tok;
        logic data1;
        logic status;
    } ucs_req_t;

    // outcome of the transaction reported by the bus engine
    typedef struct packed {
        logic valid;
        ucs_rsp_code_t code;
    } ucs_rsp_t;
endpackage

// ===== hw/ucs_ep0_host.sv
// endpoint-zero host control/status logic with an ahb-lite register slave
//****************************************************************
// How it works
//****************************************************************
// How it works
// - peripheral NAKs beyond limit: set nak_timeout_flag and halt endpoint.
// - status bit written with tx_packet_ready or in_request starts a STATUS stage transaction.
// - setting status bit without setup forces data_toggle to 1 for DATA1.
// - hardware clears status bit when the STATUS stage completes.
// - in_request issues IN; cleared when rx_packet_ready gets set.
// - three unanswered attempts set error bit and interrupt; software clears.
// - setup bit sends SETUP instead of OUT; set with tx_packet_ready.
// - setting setup bit clears data_toggle so DATA0 is sent.
// - received STALL sets stalled bit until software clears it.
// - tx_packet_ready with setup sends setup, alone sends OUT.
// - hardware clears tx_packet_ready once the packet went out.
// - received packet sets rx_packet_ready and the interrupt flag.
`timescale 1ns/1ps

module ucs_ep0_host (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output ucs_pkg::ucs_req_t link_req,
    input wire ucs_pkg::ucs_rsp_t link_rsp,
    output logic irq
);
    import ucs_pkg::*;

    typedef enum logic {ST_IDLE, ST_WAIT} ucs_state_t;

    //****************************************************************
    // bus slave
    //****************************************************************
    logic [31:0] hrdata_r;
    logic wr_pend_r;
    logic [11:0] wr_idx_r;
    logic [7:0] csr_r;
    logic [7:0] csr_nxt;
    logic [7:0] naklim_r;
    logic tog_r;
    logic tog_nxt;
    logic ists_r;
    logic ists_nxt;
    logic mask_r;
    logic irq_r;
    ucs_state_t st_r;
    ucs_state_t st_nxt;
    ucs_req_t req_r;
    logic cur_in_r;
    logic [7:0] nak_cnt_r;
    logic [7:0] nak_cnt_nxt;
    logic [1:0] tries_r;
    logic [1:0] tries_nxt;

    wire addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);
    wire [11:0] a_idx = haddr[13:2];
    wire wr_take = addr_ok && hwrite;
    wire rd_take = addr_ok && !hwrite;
    wire wr_csr = wr_pend_r && (wr_idx_r == IDX_CSR);
    wire wr_nak = wr_pend_r && (wr_idx_r == IDX_NAKLIM);
    wire wr_tog = wr_pend_r && (wr_idx_r == IDX_TOG);
    wire wr_msk = wr_pend_r && (wr_idx_r == IDX_IMASK);
    // reading the status clears it; a new event still wins below
    wire rd_clr = rd_take && (a_idx == IDX_ISTS);
    wire [7:0] wdat = hwdata[7:0];

    // unmapped indices read as zero, writes to them are dropped
    wire [7:0] rd_sel =
        (a_idx == IDX_CSR) ? csr_r :
        (a_idx == IDX_NAKLIM) ? naklim_r :
        (a_idx == IDX_TOG) ? {7'h00, tog_r} :
        (a_idx == IDX_ISTS) ? {7'h00, ists_r} :
        (a_idx == IDX_IMASK) ? {7'h00, mask_r} : 8'h00;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
            wr_pend_r <= 1'b0;
            wr_idx_r <= 12'h000;
        end else begin
            hrdata_r <= rd_take ? {24'h00_0000, rd_sel} : 32'h0000_0000;
            wr_pend_r <= wr_take;
            wr_idx_r <= a_idx;
        end
    end

    //****************************************************************
    // transaction sequencing
    //****************************************************************
    wire rsp_hit = (st_r == ST_WAIT) && link_rsp.valid;
    wire is_ack = rsp_hit && (link_rsp.code == RSP_ACK);
    wire is_data = rsp_hit && (link_rsp.code == RSP_DATA);
    wire is_nak = rsp_hit && (link_rsp.code == RSP_NAK);
    wire is_stall = rsp_hit && (link_rsp.code == RSP_STALL);
    wire is_none = rsp_hit && (link_rsp.code == RSP_NONE);
    wire nak_over = is_nak && (nak_cnt_r >= naklim_r);
    wire none_out = is_none && (tries_r == MAX_TRIES - 2'h1);
    // halted while a timeout, error or stall is pending
    wire halted = csr_r[B_NAK_TIMEOUT_FLAG] || csr_r[B_ERROR]
        || csr_r[B_STALLED];
    wire want = csr_r[B_TX_PACKET_READY] || csr_r[B_INREQ];
    wire go = (st_r == ST_IDLE) && want && !halted;
    wire done_ok = (is_ack && !cur_in_r) || (is_data && cur_in_r);
    // raising tx_packet_ready from software is itself an event
    wire tx_evt = wr_csr && wdat[B_TX_PACKET_READY] && !csr_r[B_TX_PACKET_READY];
    wire ep0_evt = tx_evt || (is_data && cur_in_r)
        || none_out || nak_over || is_stall || (is_ack && !cur_in_r);

    // in_request wins over tx_packet_ready when both are set
    wire ucs_tok_t tok_sel = csr_r[B_INREQ] ? TOK_IN :
        (csr_r[B_SETUP] ? TOK_SETUP : TOK_OUT);

    always_comb begin
        st_nxt = st_r;
        if (go) begin
            st_nxt = ST_WAIT;
        end else if (rsp_hit) begin
            st_nxt = ST_IDLE;
        end
    end

    always_comb begin
        csr_nxt = csr_r;
        tog_nxt = tog_r;
        nak_cnt_nxt = nak_cnt_r;
        tries_nxt = tries_r;
        if (wr_csr) begin
            csr_nxt = wdat;
        end
        if (wr_tog) begin
            tog_nxt = wdat[0];
        end
        if (wr_csr && wdat[B_STATUS]) begin
            tog_nxt = 1'b1;
        end
        if (wr_csr && wdat[B_SETUP]) begin
            tog_nxt = 1'b0;
        end
        if (done_ok) begin
            tog_nxt = !tog_r;
            nak_cnt_nxt = 8'h00;
            tries_nxt = 2'h0;
            csr_nxt[B_STATUS] = 1'b0;
        end
        if (is_ack && !cur_in_r) begin
            csr_nxt[B_TX_PACKET_READY] = 1'b0;
        end
        if (is_data && cur_in_r) begin
            csr_nxt[B_RX_PACKET_READY] = 1'b1;
            csr_nxt[B_INREQ] = 1'b0;
        end
        if (is_nak) begin
            nak_cnt_nxt = (nak_cnt_r == 8'hff) ? 8'hff : nak_cnt_r + 8'h01;
            tries_nxt = 2'h0;
        end
        if (nak_over) begin
            csr_nxt[B_NAK_TIMEOUT_FLAG] = 1'b1;
            nak_cnt_nxt = 8'h00;
        end
        if (is_stall) begin
            csr_nxt[B_STALLED] = 1'b1;
            nak_cnt_nxt = 8'h00;
            tries_nxt = 2'h0;
        end
        if (is_none) begin
            tries_nxt = tries_r + 2'h1;
        end
        if (none_out) begin
            csr_nxt[B_ERROR] = 1'b1;
            tries_nxt = 2'h0;
        end
    end

    // sticky event, read clears, a same-cycle event is kept
    assign ists_nxt = (ists_r && !rd_clr) || ep0_evt;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= ST_IDLE;
            csr_r <= CSR_RST;
            tog_r <= 1'b0;
            nak_cnt_r <= 8'h00;
            tries_r <= 2'h0;
            naklim_r <= NAKLIM_RST;
            mask_r <= MASK_RST[0];
            ists_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            csr_r <= csr_nxt;
            tog_r <= tog_nxt;
            nak_cnt_r <= nak_cnt_nxt;
            tries_r <= tries_nxt;
            naklim_r <= wr_nak ? wdat : naklim_r;
            mask_r <= wr_msk ? wdat[0] : mask_r;
            ists_r <= ists_nxt;
            irq_r <= ists_nxt && (wr_msk ? wdat[0] : mask_r);
        end
    end

    //****************************************************************
    // launch towards the bus engine
    //****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
            cur_in_r <= 1'b0;
        end else begin
            req_r.valid <= go;
            req_r.tok <= tok_sel;
            req_r.data1 <= tog_r;
            req_r.status <= csr_r[B_STATUS];
            cur_in_r <= go ? csr_r[B_INREQ] : cur_in_r;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link_req = req_r;
    assign irq = irq_r;

    //****************************************************************
    // checks
    //****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_issue_setup;
        go && csr_r[B_TX_PACKET_READY] && csr_r[B_SETUP] && !csr_r[B_INREQ];
    endsequence
    sequence s_setup_out;
        req_r.valid && (req_r.tok == TOK_SETUP) && !req_r.data1;
    endsequence

    a_halt_holds: assert property (
        csr_r[B_NAK_TIMEOUT_FLAG] |=> !req_r.valid)
        else $error("transaction launched while nak timeout set");
    a_nak_timeout: assert property (
        nak_over |=> csr_r[B_NAK_TIMEOUT_FLAG] ##1 !req_r.valid)
        else $error("nak limit passed without halt");
    a_status_toggle: assert property (
        wr_csr && wdat[B_STATUS] && !wdat[B_SETUP] && !rsp_hit |=> tog_r)
        else $error("status write left toggle at zero");
    a_setup_send: assert property (
        s_issue_setup |=> s_setup_out)
        else $error("setup bit did not give a setup data0 token");
    a_tx_done: assert property (
        is_ack && !cur_in_r && !wr_csr |=> !csr_r[B_TX_PACKET_READY])
        else $error("tx ready not cleared after send");
    a_in_done: assert property (
        is_data && cur_in_r |=> csr_r[B_RX_PACKET_READY] && !csr_r[B_INREQ])
        else $error("in request not cleared with rx ready");
    a_err_three: assert property (
        is_none && (tries_r == 2'h2) |=> csr_r[B_ERROR] && ists_r)
        else $error("error bit missing after three tries");
    a_stall_seen: assert property (
        is_stall |=> csr_r[B_STALLED] && !req_r.valid)
        else $error("stall not recorded");
    a_status_end: assert property (
        done_ok && !wr_csr |=> !csr_r[B_STATUS])
        else $error("status bit survived stage end");
    a_irq_level: assert property (
        ep0_evt && mask_r && !wr_msk |=> irq_r)
        else $error("masked-in event did not raise irq");
    a_setup_zero: assert property (
        wr_csr && wdat[B_SETUP] && !rsp_hit |=> !tog_r)
        else $error("setup write left toggle at one");
    a_rx_event: assert property (
        is_data && cur_in_r |=> ists_r)
        else $error("received packet raised no event");
    a_tx_event: assert property (
        tx_evt |=> ists_r)
        else $error("tx ready write raised no event");
    a_launch_pulse: assert property (
        req_r.valid |=> !req_r.valid)
        else $error("launch strobe longer than one cycle");
    a_status_launch: assert property (
        go && csr_r[B_STATUS] |=> req_r.valid && req_r.status)
        else $error("status stage not flagged at launch");
    a_in_token: assert property (
        go && csr_r[B_INREQ] |=> req_r.tok == TOK_IN)
        else $error("in request did not give an in token");
    a_out_token: assert property (
        go && !csr_r[B_INREQ] && !csr_r[B_SETUP] |=> req_r.tok == TOK_OUT)
        else $error("plain tx ready did not give an out token");
    a_err_sticky: assert property (
        csr_r[B_ERROR] && !wr_csr |=> csr_r[B_ERROR])
        else $error("error bit dropped without software");
    a_stall_sticky: assert property (
        csr_r[B_STALLED] && !wr_csr |=> csr_r[B_STALLED])
        else $error("stalled bit dropped without software");
endmodule // ucs_ep0_host

// ===== test/ucs_periph_model.sv
// behavioural peripheral answering endpoint-zero transactions
`timescale 1ns/1ps

module ucs_periph_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire ucs_pkg::ucs_req_t link_req,
    input wire ucs_pkg::ucs_rsp_code_t code,
    input wire logic [3:0] dly,
    output ucs_pkg::ucs_rsp_t link_rsp,
    output int rsp_cnt
);
    import ucs_pkg::*;
    //****
    // one answer per launch, dly+1 cycles after the launch strobe is seen
    //****
    logic busy;
    logic [3:0] cnt;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            link_rsp <= '0;
            rsp_cnt <= 0;
        end else begin
            link_rsp.valid <= 1'b0;
            // released code is inverted every cycle, so it differs from the last answer on alternate cycles
            link_rsp.code <= ucs_rsp_code_t'(~link_rsp.code);
            if (link_req.valid === 1'b1) begin
                busy <= 1'b1;
                cnt <= dly;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                link_rsp.valid <= 1'b1;
                link_rsp.code <= code;
                rsp_cnt <= rsp_cnt + 1;
            end
        end
    end
endmodule // ucs_periph_model

// ===== test/ucs_ep0_host_bench.sv
// self-checking bench for the endpoint-zero host block
`timescale 1ns/1ps

module ucs_ep0_host_bench;
    import ucs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd_q, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] dly;
    ucs_req_t link_req, last_req;
    ucs_rsp_t link_rsp;
    ucs_rsp_code_t code;
    int rsp_cnt, t;
    int n_launch = 0;
    int n_mismatch = 0;
    int check_count = 0;

    ucs_ep0_host DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_req(link_req),
        .link_rsp(link_rsp), .irq(irq));
    ucs_periph_model peer (.hclk(hclk), .hresetn(hresetn),
        .link_req(link_req), .code(code), .dly(dly),
        .link_rsp(link_rsp), .rsp_cnt(rsp_cnt));

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        rd_q <= hrdata;
        if (link_req.valid === 1'b1) begin
            n_launch <= n_launch + 1;
            last_req <= link_req;
        end
    end
    //****
    // bus and check tasks
    //****
    task automatic bus(input logic [11:0] idx, input logic wr,
            input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        // data was captured at that edge by rd_q
        #1 q = rd_q;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic rd(input logic [11:0] idx, input logic [31:0] e,
            input string nm);
        bus(idx, 1'b0, 32'h0);
        chk(nm, q, e);
    endtask
    // csr write, then wait for n answers of the peer
    task automatic run(input logic [7:0] v, input ucs_rsp_code_t c,
            input int n);
        int t0;
        int k;
        t0 = rsp_cnt;
        k = 0;
        code <= c;
        bus(IDX_CSR, 1'b1, {24'h0, v});
        while (rsp_cnt < t0 + n && k < 300) begin
            @(posedge hclk);
            k++;
        end
        if (k == 300)
            n_mismatch++;
        repeat (3) @(posedge hclk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    //****
    // tests
    //****
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        code = RSP_ACK;
        dly = 4'h2;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd(IDX_CSR, 32'h0, "csr reset");
        bus(IDX_IMASK, 1'b1, 32'h1);
        // toggle preset to one so the setup write really has to clear it
        bus(IDX_TOG, 1'b1, 32'h1);
        rd(IDX_TOG, 32'h1, "toggle preset");
        run(8'h0a, RSP_ACK, 1);
        chk("setup tok", 32'(last_req.tok), 32'(TOK_SETUP));
        chk("setup data1", 32'(last_req.data1), 32'h0);
        rd(IDX_CSR, 32'h08, "csr setup done");
        chk("irq high", 32'(irq), 32'h1);
        rd(IDX_ISTS, 32'h1, "ists set");
        rd(IDX_ISTS, 32'h0, "ists cleared");
        chk("irq low", 32'(irq), 32'h0);
        $display("test setup done");
        dly <= 4'hc;
        // toggle preset to zero so the status write really has to set it
        bus(IDX_TOG, 1'b1, 32'h0);
        run(8'h42, RSP_ACK, 1);
        chk("out tok", 32'(last_req.tok), 32'(TOK_OUT));
        chk("status data1", 32'(last_req.data1), 32'h1);
        chk("status flag", 32'(last_req.status), 32'h1);
        rd(IDX_CSR, 32'h0, "csr status done");
        $display("test status done");
        run(8'h20, RSP_DATA, 1);
        chk("in tok", 32'(last_req.tok), 32'(TOK_IN));
        rd(IDX_CSR, 32'h01, "csr rx ready");
        bus(IDX_CSR, 1'b1, 32'h0);
        $display("test in done");
        t = n_launch;
        run(8'h20, RSP_STALL, 1);
        repeat (20) @(posedge hclk);
        rd(IDX_CSR, 32'h24, "csr stalled");
        chk("stall launches", 32'(n_launch - t), 32'h1);
        bus(IDX_CSR, 1'b1, 32'h0);
        $display("test stall done");
        bus(IDX_IMASK, 1'b1, 32'h0);
        t = n_launch;
        dly <= 4'h0;
        run(8'h02, RSP_NONE, 3);
        chk("error tries", 32'(n_launch - t), 32'h3);
        rd(IDX_CSR, 32'h12, "csr error");
        chk("irq masked", 32'(irq), 32'h0);
        rd(IDX_ISTS, 32'h1, "ists error");
        bus(IDX_CSR, 1'b1, 32'h0);
        $display("test error done");
        bus(IDX_NAKLIM, 1'b1, 32'h2);
        rd(IDX_NAKLIM, 32'h2, "nak limit");
        t = n_launch;
        run(8'h20, RSP_NAK, 3);
        rd(IDX_CSR, 32'ha0, "csr nak timeout");
        repeat (20) @(posedge hclk);
        chk("halted", 32'(n_launch - t), 32'h3);
        run(8'h20, RSP_DATA, 1);
        rd(IDX_CSR, 32'h01, "csr resumed");
        bus(12'h0ff, 1'b1, 32'hff);
        rd(12'h0ff, 32'h0, "unmapped");
        $display("test timeout done");
        give_verdict();
    end
endmodule // ucs_ep0_host_bench
